// *** rtl/hpsc_defines.vh ***
// Summary of operation
// - each spi byte received shifts exactly one byte out, full duplex.
// - returned byte is next pending stream byte, or 0xff when none remains.
// - incoming spi bytes are message input only; no writable registers.
// - select strap 0 gives spi; strap 1 gives serial port plus i2c.
// - pins pair output/transmit, input/receive, select/i2c data, clock/i2c clock.
// - external reset low for at least 100 ms starts a cold start.
// - recovery strap low at power-up enters recovery boot, navigation disabled.
// - in recovery boot usb is out of service; serial, i2c, spi remain.
// - external interrupt inputs stay inactive after reset until configured.
// - enabled supervisor checks open and short, removes antenna power on short.
// - no antenna status reported unless voltage control enable is 1.
// - power disable output active high; low when enabled and no fault.
// - presence input high means antenna connected, low means not detected.
// - with antenna connected status goes initialising then ok.
// - parsing stops after 50 consecutive 0xff bytes, resumes on other byte.
`ifndef HPSC_DEFINES_VH
`define HPSC_DEFINES_VH
`define HPSC_CLK_KHZ 40000
`define HPSC_COLD_START_MS 100
`define HPSC_IDLE_BYTE 8'hff
`define HPSC_FF_STOP_COUNT 6'h32
`define HPSC_STRAP_DELAY 2'h2
`define HPSC_ANT_INIT_CYCLES 16'h0010
`define HPSC_ANT_RECOVER_CYCLES 16'h9c40
`define HPSC_STAT_NONE 3'h0
`define HPSC_STAT_INIT 3'h1
`define HPSC_STAT_OK 3'h2
`define HPSC_STAT_SHORT 3'h3
`define HPSC_STAT_OPEN 3'h4
`define HPSC_FIFO_DEPTH 16
`define HPSC_FIFO_AW 4
`endif

// *** rtl/hpsc_sync.v ***
`timescale 1ns/100ps
`default_nettype none
module hpsc_sync #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b1}}
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] din,
	output reg [W-1:0] dout
);
	reg [W-1:0] meta;
	// meta feeds only dout
	always @(posedge clk) begin
		if (rst) begin
			meta <= INIT;
			dout <= INIT;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule
`default_nettype wire

// *** rtl/hpsc_fifo.v ***
`timescale 1ns/100ps
`default_nettype none
module hpsc_fifo #(
	parameter W = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire rst,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;
	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
	always @(posedge clk) begin
		if (rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push & ~pop) begin
				count <= count + 1'b1;
			end else if (pop & ~push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** rtl/hpsc_top.v ***
`include "hpsc_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module hpsc_top #(
	parameter CNT_W = 22,
	parameter [CNT_W-1:0] COLD_START_CYCLES = `HPSC_COLD_START_MS * `HPSC_CLK_KHZ,
	parameter [15:0] ANT_INIT_CYCLES = `HPSC_ANT_INIT_CYCLES,
	parameter [15:0] ANT_RECOVER_CYCLES = `HPSC_ANT_RECOVER_CYCLES
) (
	// clock and reset
	input wire CLK,
	input wire RST,
	// straps and external reset pin
	input wire PORT_SELECT_STRAP,
	input wire RECOVERY_STRAP_N,
	input wire EXT_RESET_N,
	output reg COLD_START,
	output reg PORT_SELECT,
	output reg RECOVERY_MODE,
	output wire NAV_ENABLE,
	output wire USB_ENABLE,
	// shared pins 42..45
	output reg PIN_TX_OUT,
	output wire PIN_TX_OE,
	input wire PIN_RX_IN,
	input wire PIN_SEL_SDA_IN,
	output wire PIN_SEL_SDA_OUT,
	output wire PIN_SEL_SDA_OE,
	input wire PIN_CLK_SCL_IN,
	// first serial port and i2c side
	input wire SERIAL_TXD,
	output wire SERIAL_RXD,
	output wire I2C_SDA_IN,
	input wire I2C_SDA_DRIVE_LOW,
	output wire I2C_SCL_IN,
	// outgoing message stream
	input wire TX_VALID,
	output wire TX_READY,
	input wire [7:0] TX_DATA,
	// incoming message bytes
	output reg RX_VALID,
	output reg [7:0] RX_DATA,
	output wire RX_PARSING,
	// time pulse sharing the recovery strap line
	input wire SECOND_TIME_PULSE_IN,
	input wire SECOND_TIME_PULSE_EN,
	output reg SECOND_TIME_PULSE_OUT,
	output wire SECOND_TIME_PULSE_OE,
	// external interrupts
	input wire [1:0] EXT_INTR_PIN,
	input wire [1:0] EXT_INTR_CFG,
	input wire EXT_INTR_CFG_LOAD,
	output reg [1:0] EXT_INTR_EVENT,
	// antenna supervisor
	input wire ANTENNA_VOLTAGE_CONTROL_ENABLE,
	input wire ANT_SHORT_DET_EN,
	input wire ANT_OPEN_DET_EN,
	input wire ANT_RECOVER_EN,
	input wire ANTENNA_PRESENCE_INPUT,
	input wire ANTENNA_SHORT_LOW,
	output reg ANTENNA_POWER_DISABLE,
	output reg [2:0] ANT_STATUS
);
	localparam [4:0] A_OFF = 5'h01;
	localparam [4:0] A_INIT = 5'h02;
	localparam [4:0] A_OK = 5'h04;
	localparam [4:0] A_SHORT = 5'h08;
	localparam [4:0] A_OPEN = 5'h10;
	function is_idle;
		input [7:0] b;
		begin
			is_idle = (b == `HPSC_IDLE_BYTE);
		end
	endfunction
	// pin synchronisers; idle levels high
	wire [9:0] raw_pins;
	wire [9:0] s_pins;
	assign raw_pins = {PORT_SELECT_STRAP, RECOVERY_STRAP_N, EXT_RESET_N, PIN_RX_IN, PIN_SEL_SDA_IN,
		PIN_CLK_SCL_IN, EXT_INTR_PIN, ANTENNA_PRESENCE_INPUT, ANTENNA_SHORT_LOW};
	hpsc_sync #(.W(10), .INIT(10'h3ff)) u_sync (
		.clk(CLK),
		.rst(RST),
		.din(raw_pins),
		.dout(s_pins)
	);
	wire s_sel_strap = s_pins[9];
	wire s_rec_n = s_pins[8];
	wire s_ext_rst_n = s_pins[7];
	wire s_rx = s_pins[6];
	wire s_cs_sda = s_pins[5];
	wire s_clk_scl = s_pins[4];
	wire [1:0] s_intr = s_pins[3:2];
	wire s_present = s_pins[1];
	wire s_short_n = s_pins[0];
	// strap capture after the synchronisers have settled
	reg [1:0] strap_cnt;
	reg strap_taken;
	always @(posedge CLK) begin
		if (RST) begin
			strap_cnt <= 2'h0;
			strap_taken <= 1'b0;
			PORT_SELECT <= 1'b1;
			RECOVERY_MODE <= 1'b0;
		end else if (!strap_taken) begin
			strap_cnt <= strap_cnt + 2'h1;
			if (strap_cnt == `HPSC_STRAP_DELAY) begin
				strap_taken <= 1'b1;
				PORT_SELECT <= s_sel_strap;
				RECOVERY_MODE <= ~s_rec_n;
			end
		end
	end
	assign NAV_ENABLE = strap_taken & ~RECOVERY_MODE;
	assign USB_ENABLE = strap_taken & ~RECOVERY_MODE;
	// time-pulse pin stays released until the strap is read
	assign SECOND_TIME_PULSE_OE = strap_taken & SECOND_TIME_PULSE_EN;
	// cold start after a long external reset, one pulse per hold
	reg [CNT_W-1:0] rst_cnt;
	reg cold_done;
	always @(posedge CLK) begin
		if (RST) begin
			rst_cnt <= {CNT_W{1'b0}};
			cold_done <= 1'b0;
			COLD_START <= 1'b0;
		end else begin
			COLD_START <= 1'b0;
			if (s_ext_rst_n) begin
				rst_cnt <= {CNT_W{1'b0}};
				cold_done <= 1'b0;
			end else if (!cold_done) begin
				if (rst_cnt == COLD_START_CYCLES - 1'b1) begin
					COLD_START <= 1'b1;
					cold_done <= 1'b1;
				end else begin
					rst_cnt <= rst_cnt + 1'b1;
				end
			end
		end
	end
	// port mux
	wire spi_mode = strap_taken & ~PORT_SELECT;
	wire spi_cs = spi_mode & ~s_cs_sda;
	reg spi_miso;
	assign PIN_TX_OE = PORT_SELECT | spi_cs;
	always @(posedge CLK) begin
		if (RST) begin
			PIN_TX_OUT <= 1'b1;
			SECOND_TIME_PULSE_OUT <= 1'b0;
		end else begin
			PIN_TX_OUT <= PORT_SELECT ? SERIAL_TXD : spi_miso;
			SECOND_TIME_PULSE_OUT <= SECOND_TIME_PULSE_IN;
		end
	end
	assign SERIAL_RXD = PORT_SELECT ? s_rx : 1'b1;
	assign I2C_SDA_IN = PORT_SELECT ? s_cs_sda : 1'b1;
	assign I2C_SCL_IN = PORT_SELECT ? s_clk_scl : 1'b1;
	assign PIN_SEL_SDA_OUT = 1'b0;
	assign PIN_SEL_SDA_OE = PORT_SELECT & I2C_SDA_DRIVE_LOW;
	// outgoing stream buffer
	wire fifo_valid;
	wire [7:0] fifo_data;
	reg fifo_pop;
	hpsc_fifo #(.W(8), .DEPTH(`HPSC_FIFO_DEPTH), .AW(`HPSC_FIFO_AW)) u_fifo (
		.clk(CLK),
		.rst(RST),
		.in_valid(TX_VALID),
		.in_ready(TX_READY),
		.in_data(TX_DATA),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);
	wire [7:0] next_out_byte = fifo_valid ? fifo_data : `HPSC_IDLE_BYTE;
	// spi slave, mode 0: sample on rising, shift on falling
	reg clk_prev;
	reg tx_from_fifo;
	reg cs_prev;
	reg [2:0] bit_cnt;
	reg [7:0] rx_shift;
	reg [7:0] tx_shift;
	reg load_pending;
	reg [5:0] ff_run;
	wire sclk_rise = spi_cs & s_clk_scl & ~clk_prev;
	wire sclk_fall = spi_cs & ~s_clk_scl & clk_prev;
	wire cs_start = spi_cs & ~cs_prev;
	wire [7:0] rx_byte = {rx_shift[6:0], s_rx};
	wire byte_done = sclk_rise & (bit_cnt == 3'h7);
	assign RX_PARSING = (ff_run != `HPSC_FF_STOP_COUNT);
	always @* begin
		spi_miso = tx_shift[7];
		fifo_pop = fifo_valid & tx_from_fifo & byte_done;
	end
	always @(posedge CLK) begin
		if (RST) begin
			clk_prev <= 1'b0;
			cs_prev <= 1'b0;
			bit_cnt <= 3'h0;
			rx_shift <= 8'h00;
			tx_shift <= `HPSC_IDLE_BYTE;
			load_pending <= 1'b0;
			tx_from_fifo <= 1'b0;
			ff_run <= 6'h00;
			RX_VALID <= 1'b0;
			RX_DATA <= 8'h00;
		end else begin
			clk_prev <= s_clk_scl;
			cs_prev <= spi_cs;
			RX_VALID <= 1'b0;
			if (!spi_cs) begin
				bit_cnt <= 3'h0;
				load_pending <= 1'b0;
			end else if (cs_start) begin
				tx_shift <= next_out_byte;
				tx_from_fifo <= fifo_valid;
				bit_cnt <= 3'h0;
				load_pending <= 1'b0;
			end else begin
				if (sclk_rise) begin
					rx_shift <= rx_byte;
					bit_cnt <= bit_cnt + 3'h1;
					load_pending <= byte_done;
					tx_from_fifo <= tx_from_fifo & ~byte_done;
				end
				if (sclk_fall) begin
					// peek only; the pop waits for the 8th bit, so a cs rise between bytes loses none
					if (load_pending) begin
						tx_shift <= next_out_byte;
						tx_from_fifo <= fifo_valid;
						load_pending <= 1'b0;
					end else begin
						tx_shift <= {tx_shift[6:0], 1'b1};
					end
				end
			end
			// received bytes only feed the message parser, never registers
			if (byte_done) begin
				if (is_idle(rx_byte)) begin
					if (RX_PARSING) begin
						ff_run <= ff_run + 6'h01;
						RX_VALID <= 1'b1;
						RX_DATA <= rx_byte;
					end
				end else begin
					ff_run <= 6'h00;
					RX_VALID <= 1'b1;
					RX_DATA <= rx_byte;
				end
			end
		end
	end
	// external interrupts, off until loaded
	reg [1:0] intr_en;
	reg [1:0] intr_prev;
	always @(posedge CLK) begin
		if (RST) begin
			intr_en <= 2'h0;
			intr_prev <= 2'h3;
			EXT_INTR_EVENT <= 2'h0;
		end else begin
			if (EXT_INTR_CFG_LOAD) begin
				intr_en <= EXT_INTR_CFG;
			end
			intr_prev <= s_intr;
			EXT_INTR_EVENT <= s_intr & ~intr_prev & intr_en;
		end
	end
	// antenna supervisor
	reg [4:0] ant_state;
	reg [4:0] next_ant_state;
	reg [15:0] ant_cnt;
	wire short_seen = ANT_SHORT_DET_EN & ~s_short_n;
	wire open_seen = ANT_OPEN_DET_EN & ~s_present;
	wire ant_tick = (ant_state == A_INIT) ? (ant_cnt == ANT_INIT_CYCLES) :
		(ant_cnt == ANT_RECOVER_CYCLES);
	always @* begin
		next_ant_state = ant_state;
		case (ant_state)
			A_OFF: begin
				next_ant_state = A_INIT;
			end
			A_INIT: begin
				if (ant_tick) begin
					if (short_seen) begin
						next_ant_state = A_SHORT;
					end else if (open_seen) begin
						next_ant_state = A_OPEN;
					end else begin
						next_ant_state = A_OK;
					end
				end
			end
			A_OK, A_OPEN: begin
				if (short_seen) begin
					next_ant_state = A_SHORT;
				end else if (open_seen) begin
					next_ant_state = A_OPEN;
				end else begin
					next_ant_state = A_OK;
				end
			end
			A_SHORT: begin
				// sticky unless recovery retest, short detection toggled off or voltage control enable dropped
				if (!ANT_SHORT_DET_EN || (ANT_RECOVER_EN && ant_tick)) begin
					next_ant_state = A_INIT;
				end
			end
			default: begin
				next_ant_state = A_OFF;
			end
		endcase
		if (!ANTENNA_VOLTAGE_CONTROL_ENABLE) begin
			next_ant_state = A_OFF;
		end
	end
	always @(posedge CLK) begin
		if (RST) begin
			ant_state <= A_OFF;
			ant_cnt <= 16'h0000;
			ANTENNA_POWER_DISABLE <= 1'b0;
			ANT_STATUS <= `HPSC_STAT_NONE;
		end else begin
			ant_state <= next_ant_state;
			if (next_ant_state != ant_state) begin
				ant_cnt <= 16'h0000;
			end else if (!ant_tick) begin
				ant_cnt <= ant_cnt + 16'h0001;
			end
			ANTENNA_POWER_DISABLE <= (next_ant_state == A_SHORT);
			case (next_ant_state)
				A_INIT: ANT_STATUS <= `HPSC_STAT_INIT;
				A_OK: ANT_STATUS <= `HPSC_STAT_OK;
				A_SHORT: ANT_STATUS <= `HPSC_STAT_SHORT;
				A_OPEN: ANT_STATUS <= `HPSC_STAT_OPEN;
				default: ANT_STATUS <= `HPSC_STAT_NONE;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** verification/hpsc_top_assertions.sv ***
`include "hpsc_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module hpsc_top_assertions #(
	parameter int COLD_START_CYCLES = 20
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// straps, reset pin, modes
	input wire logic EXT_RESET_N,
	input wire logic COLD_START,
	input wire logic PORT_SELECT,
	input wire logic RECOVERY_MODE,
	input wire logic NAV_ENABLE,
	input wire logic USB_ENABLE,
	// shared pins and serial side
	input wire logic PIN_TX_OUT,
	input wire logic PIN_TX_OE,
	input wire logic PIN_RX_IN,
	input wire logic SERIAL_TXD,
	input wire logic SERIAL_RXD,
	input wire logic PIN_SEL_SDA_OE,
	input wire logic I2C_SDA_DRIVE_LOW,
	// interrupts and antenna
	input wire logic [1:0] EXT_INTR_PIN,
	input wire logic [1:0] EXT_INTR_EVENT,
	input wire logic ANTENNA_VOLTAGE_CONTROL_ENABLE,
	input wire logic ANTENNA_POWER_DISABLE,
	input wire logic [2:0] ANT_STATUS
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	logic [2:0] age;
	logic [31:0] lows;
	// straps settle a few edges after release, so mode checks wait
	wire up = age == 3'h7;
	always @(posedge CLK) begin
		if (RST)
			age <= 3'h0;
		else if (!up)
			age <= age + 3'h1;
		lows <= EXT_RESET_N ? 32'h0 : lows + 32'h1;
	end
	property p_tx_oe; up && PORT_SELECT |-> PIN_TX_OE; endproperty
	a_tx_oe: assert property (p_tx_oe) else $error("tx pin idle in serial mode");
	property p_rx_pair;
		up && $stable(PIN_RX_IN) && PIN_RX_IN == $past(PIN_RX_IN, 2) |-> SERIAL_RXD == (PIN_RX_IN || !PORT_SELECT);
	endproperty
	a_rx_pair: assert property (p_rx_pair) else $error("serial rx not paired");
	property p_tx_pair; up && PORT_SELECT |=> PIN_TX_OUT == $past(SERIAL_TXD); endproperty
	a_tx_pair: assert property (p_tx_pair) else $error("serial tx not paired");
	property p_sda_oe; PIN_SEL_SDA_OE == (PORT_SELECT && I2C_SDA_DRIVE_LOW); endproperty
	a_sda_oe: assert property (p_sda_oe) else $error("sda drive wrong");
	property p_strap_hold; up |-> $stable(PORT_SELECT) && $stable(RECOVERY_MODE); endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap changed while running");
	property p_recovery; RECOVERY_MODE |-> !NAV_ENABLE && !USB_ENABLE; endproperty
	a_recovery: assert property (p_recovery) else $error("recovery left nav or usb on");
	property p_cold;
		COLD_START |-> (lows >= COLD_START_CYCLES && lows <= COLD_START_CYCLES + 4) ##1 !COLD_START;
	endproperty
	a_cold: assert property (p_cold) else $error("cold start timing wrong");
	property p_intr;
		EXT_INTR_EVENT[0] |-> $past(EXT_INTR_PIN[0], 3) && !$past(EXT_INTR_PIN[0], 4);
	endproperty
	a_intr: assert property (p_intr) else $error("interrupt event without pin edge");
	property p_ant_none;
		!ANTENNA_VOLTAGE_CONTROL_ENABLE [*5] |-> ANT_STATUS == `HPSC_STAT_NONE && !ANTENNA_POWER_DISABLE;
	endproperty
	a_ant_none: assert property (p_ant_none) else $error("antenna status while disabled");
	property p_ant_pwr; ANTENNA_POWER_DISABLE == (ANT_STATUS == `HPSC_STAT_SHORT); endproperty
	a_ant_pwr: assert property (p_ant_pwr) else $error("antenna power disable wrong");
	c_cold: cover property (COLD_START);
	c_short: cover property (ANT_STATUS == `HPSC_STAT_SHORT);
	c_serial: cover property (up && PORT_SELECT && !SERIAL_RXD);
endmodule
`default_nettype wire

// *** verification/hpsc_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module hpsc_host (
	// clock and miso
	input wire logic clk,
	input wire logic miso,
	// spi master lines
	output logic cs_n,
	output logic sck,
	output logic mosi
);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		mosi = 1'b1;
	end
	task automatic half;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic xfer(input logic [7:0] o, output logic [7:0] r);
		integer i;
		cs_n = 1'b0;
		for (i = 7; i >= 0; i--) begin
			mosi = o[i];
			half;
			sck = 1'b1;
			half;
			// late in the high phase, miso has long settled
			r[i] = miso;
			sck = 1'b0;
		end
		half;
		cs_n = 1'b1;
		// released line must not look held
		mosi = ~mosi;
		half;
	endtask
endmodule
`default_nettype wire

// *** verification/hpsc_top_tb.sv ***
`include "hpsc_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module hpsc_top_tb;
	logic clk = 0, rst = 1, strap = 0, rec_n = 1, ext_n = 1, txd = 1, rxd = 1, ser = 0, sdlo = 0;
	logic tv = 0, cl = 0, vce = 0, sde = 1, aop = 1, pres = 1, shn = 1, tpi = 0, tpe = 1;
	logic [7:0] td = 0, d[0:19], q[$];
	logic [1:0] ip = 0, ic = 0;
	logic [31:0] seed = 32'h5ed27e07;
	int n_mismatch = 0, checks_done = 0, ncold = 0, nev = 0, i, n;
	wire cs_n, sck, mosi, ps, rm, nav, usb, cold, txo, txoe, sdoe, srxd, sdain, trdy, rxv, par, apd;
	wire [7:0] rxb;
	wire [1:0] ev;
	wire [2:0] ast;
	wire sel = cs_n & ~sdoe;
	wire rxin = ser ? rxd : mosi;
	wire tpo, tpoe, sclin, sdout;
	// released output pin shows the inverse, so a late drive is caught
	wire miso = txoe ? txo : ~txo;
	hpsc_top #(.COLD_START_CYCLES(22'd20)) hpsc_top_i (.CLK(clk), .RST(rst), .PORT_SELECT_STRAP(strap),
		.RECOVERY_STRAP_N(rec_n), .EXT_RESET_N(ext_n), .COLD_START(cold), .PORT_SELECT(ps), .RECOVERY_MODE(rm),
		.NAV_ENABLE(nav), .USB_ENABLE(usb), .PIN_TX_OUT(txo), .PIN_TX_OE(txoe), .PIN_RX_IN(rxin),
		.PIN_SEL_SDA_IN(sel), .PIN_SEL_SDA_OUT(sdout), .PIN_SEL_SDA_OE(sdoe), .PIN_CLK_SCL_IN(sck), .SERIAL_TXD(txd),
		.SERIAL_RXD(srxd), .I2C_SDA_IN(sdain), .I2C_SDA_DRIVE_LOW(sdlo), .I2C_SCL_IN(sclin), .TX_VALID(tv),
		.TX_READY(trdy), .TX_DATA(td), .RX_VALID(rxv), .RX_DATA(rxb), .RX_PARSING(par), .SECOND_TIME_PULSE_IN(tpi),
		.SECOND_TIME_PULSE_EN(tpe), .SECOND_TIME_PULSE_OUT(tpo), .SECOND_TIME_PULSE_OE(tpoe), .EXT_INTR_PIN(ip),
		.EXT_INTR_CFG(ic), .EXT_INTR_CFG_LOAD(cl), .EXT_INTR_EVENT(ev), .ANTENNA_VOLTAGE_CONTROL_ENABLE(vce),
		.ANT_SHORT_DET_EN(sde), .ANT_OPEN_DET_EN(aop), .ANT_RECOVER_EN(1'b0), .ANTENNA_PRESENCE_INPUT(pres),
		.ANTENNA_SHORT_LOW(shn), .ANTENNA_POWER_DISABLE(apd), .ANT_STATUS(ast));
	hpsc_host hpsc_host_i (.clk(clk), .miso(miso), .cs_n(cs_n), .sck(sck), .mosi(mosi));
	initial forever #12.5 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic push(input logic [7:0] b);
		tv = 1;
		td = b;
		step(1);
	endtask
	task automatic spi(input logic [7:0] o, input logic [7:0] e, input bit x);
		logic [7:0] r;
		if (x)
			q.push_back(o);
		hpsc_host_i.xfer(o, r);
		chk(r, e);
	endtask
	task automatic fin(input string s);
		$display("test done: %s", s);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// receive monitor; an empty queue means no byte was due
	always @(posedge clk) begin
		if (rxv === 1'b1)
			chk(rxb, q.size() ? q.pop_front() : 9'h100);
		if (cold === 1'b1)
			ncold++;
		if (ev[0] === 1'b1)
			nev++;
		if (ev[1] === 1'b1)
			nev++;
	end
	initial begin
		#500000;
		n_mismatch++;
		print_verdict;
	end
	initial begin
		step(2);
		rst = 0;
		step(8);
		chk({ps, rm, nav, usb, tpoe, sclin, srxd, sdain, sdout}, 9'h07e);
		for (i = 0; i < 3; i++) begin
			seed = xs(seed);
			d[i] = seed[7:0];
			push(d[i]);
		end
		tv = 0;
		for (i = 0; i < 4; i++) begin
			seed = xs(seed);
			spi(seed[7:0] & 8'h7f, i < 3 ? d[i] : 8'hff, 1);
		end
		fin("stream");
		n = 0;
		while (trdy === 1'b1 && n < 20) begin
			seed = xs(seed);
			d[n] = seed[7:0];
			push(d[n]);
			n++;
		end
		td = 8'h5a;
		step(2);
		tv = 0;
		chk(n, 16);
		// idle host sends 0xff while it drains, with random stalls
		for (i = 0; i < 52; i++) begin
			spi(8'hff, i < 16 ? d[i] : 8'hff, i < 50);
			seed = xs(seed);
			step(seed[3:0]);
		end
		step(8);
		chk(par, 0);
		spi(8'h3c, 8'hff, 1);
		step(8);
		chk(par, 1);
		chk(q.size(), 0);
		fin("buffer");
		ext_n = 0;
		step(30);
		ext_n = 1;
		step(8);
		chk(ncold, 1);
		ext_n = 0;
		step(15);
		ext_n = 1;
		step(8);
		chk(ncold, 1);
		fin("cold start");
		ip = 2'h3;
		step(6);
		ip = 0;
		step(6);
		chk(nev, 0);
		ic = 2'h3;
		cl = 1;
		step(1);
		cl = 0;
		ip = 2'h3;
		step(6);
		ip = 0;
		step(6);
		chk(nev, 2);
		fin("interrupts");
		chk({apd, ast}, 4'h0);
		vce = 1;
		step(6);
		chk(ast, `HPSC_STAT_INIT);
		step(24);
		chk({apd, ast}, {1'b0, `HPSC_STAT_OK});
		pres = 0;
		step(6);
		chk(ast, `HPSC_STAT_OPEN);
		shn = 0;
		step(6);
		chk({apd, ast}, {1'b1, `HPSC_STAT_SHORT});
		shn = 1;
		pres = 1;
		step(6);
		chk(ast, `HPSC_STAT_SHORT);
		fin("antenna");
		rst = 1;
		strap = 1;
		rec_n = 0;
		ser = 1;
		step(2);
		rst = 0;
		chk(tpoe, 0);
		step(8);
		strap = 0;
		rec_n = 1;
		rxd = 0;
		txd = 0;
		sdlo = 1;
		tpi = 1;
		step(6);
		chk({ps, rm, nav, usb}, 4'hc);
		chk({srxd, txo, sdain, txoe, sclin, sdout, tpo, tpoe}, 8'h13);
		// two framed 0x55 training bytes, then the line idles high
		for (i = 0; i < 20; i++) begin
			rxd = i[0];
			step(4);
			chk(srxd, i[0]);
		end
		rxd = 1;
		fin("straps");
		print_verdict;
	end
endmodule
bind hpsc_top hpsc_top_assertions #(.COLD_START_CYCLES(COLD_START_CYCLES)) hpsc_top_assertions_i (
	.CLK(CLK), .RST(RST), .EXT_RESET_N(EXT_RESET_N), .COLD_START(COLD_START), .PORT_SELECT(PORT_SELECT),
	.RECOVERY_MODE(RECOVERY_MODE), .NAV_ENABLE(NAV_ENABLE), .USB_ENABLE(USB_ENABLE), .PIN_TX_OUT(PIN_TX_OUT),
	.PIN_TX_OE(PIN_TX_OE), .PIN_RX_IN(PIN_RX_IN), .SERIAL_TXD(SERIAL_TXD), .SERIAL_RXD(SERIAL_RXD),
	.PIN_SEL_SDA_OE(PIN_SEL_SDA_OE), .I2C_SDA_DRIVE_LOW(I2C_SDA_DRIVE_LOW), .EXT_INTR_PIN(EXT_INTR_PIN),
	.EXT_INTR_EVENT(EXT_INTR_EVENT), .ANTENNA_VOLTAGE_CONTROL_ENABLE(ANTENNA_VOLTAGE_CONTROL_ENABLE),
	.ANTENNA_POWER_DISABLE(ANTENNA_POWER_DISABLE), .ANT_STATUS(ANT_STATUS));
`default_nettype wire
